// ==== hw/lcd_cmd_decoder.sv ====
// Purpose: host bus command decoder with display ram and write buffer
// Assumes: bus strobes are one-cycle pulses synchronous to clk
// Notes: data writes pass through a small fifo drained into ram
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// write buffer
// ----------------------------------------------------------------
module lcd_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= push ? AW'(wr_ptr + 1'b1) : wr_ptr;
      rd_ptr <= pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
      count <= (AW+1)'(count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end
  end
endmodule

// ----------------------------------------------------------------
// command decoder
// ----------------------------------------------------------------
module lcd_cmd_decoder (
  input wire logic clk,
  input wire logic rst,
  input wire logic hardware_reset_n,
  input wire logic serial_mode,
  input wire logic [1:0] duty_sel,
  input wire logic command_data_select,
  input wire logic rd_strobe,
  input wire logic wr_strobe,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  output logic wr_ready,
  input wire logic refresh_req,
  input wire logic [3:0] refresh_page,
  input wire logic [7:0] refresh_col,
  output logic [7:0] refresh_data,
  output lcd_pkg::lcd_cfg_type cfg,
  output logic [3:0] bias_den,
  output logic power_save
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] ram [lcd_pkg::LCD_RAM_WORDS];
  lcd_pkg::lcd_state_type state;
  lcd_pkg::lcd_state_type next_state;
  lcd_pkg::lcd_cfg_type next_cfg;
  logic [3:0] init_cnt;
  logic [7:0] column;
  logic [7:0] next_column;
  logic [7:0] col_saved;
  logic [3:0] page;
  logic [3:0] next_page;
  logic rmw;
  logic next_rmw;
  logic [7:0] read_latch;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire hard_rst = rst || !hardware_reset_n;
  wire initializing = (state == lcd_pkg::LCD_ST_INIT);
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire drain_ready = !refresh_req;
  lcd_pkg::lcd_wr_type fifo_in;
  lcd_pkg::lcd_wr_type fifo_out;
  wire fifo_empty = !fifo_out_valid;
  wire busy = initializing || !fifo_empty;
  wire cmd_wr = wr_strobe && !command_data_select && !busy;
  wire data_wr = wr_strobe && command_data_select && fifo_in_ready;
  wire data_rd = rd_strobe && command_data_select && !serial_mode && fifo_empty;
  wire any_rd = rd_strobe && !(command_data_select && serial_mode);
  wire [7:0] cmd_bit0 = data_in & lcd_pkg::LCD_MASK_BIT0;
  wire [7:0] cmd_nib = data_in & lcd_pkg::LCD_MASK_NIB;
  wire [7:0] cmd_3bit = data_in & lcd_pkg::LCD_MASK_3BIT;
  wire is_disp = (cmd_bit0 == lcd_pkg::LCD_CMD_DISP_OFF);
  wire is_seg = (cmd_bit0 == lcd_pkg::LCD_CMD_SEG_DIR);
  wire is_bias = (cmd_bit0 == lcd_pkg::LCD_CMD_BIAS);
  wire is_all_on = (cmd_bit0 == lcd_pkg::LCD_CMD_ALL_ON);
  wire is_invert = (cmd_bit0 == lcd_pkg::LCD_CMD_INVERT);
  wire is_rmw = (data_in == lcd_pkg::LCD_CMD_RMW);
  wire is_end = (data_in == lcd_pkg::LCD_CMD_END);
  wire is_reset = (data_in == lcd_pkg::LCD_CMD_RESET);
  wire is_col_hi = (cmd_nib == lcd_pkg::LCD_PFX_COL_HI);
  wire is_col_lo = (cmd_nib == lcd_pkg::LCD_PFX_COL_LO);
  wire is_page = (cmd_nib == lcd_pkg::LCD_PFX_PAGE) && (data_in[3:0] <= lcd_pkg::LCD_PAGE_LAST);
  wire is_com = (cmd_nib == lcd_pkg::LCD_PFX_COM);
  wire is_test = (cmd_nib == lcd_pkg::LCD_PFX_TEST);
  wire is_power = (cmd_3bit == lcd_pkg::LCD_PFX_POWER);
  wire is_ratio = (cmd_3bit == lcd_pkg::LCD_PFX_RATIO);
  wire is_line = ((data_in & lcd_pkg::LCD_MASK_LINE) == lcd_pkg::LCD_PFX_LINE);
  wire reset_cmd = cmd_wr && is_reset;
  wire [7:0] status_byte = {busy, !cfg.seg_reverse, !cfg.display_on, initializing, 4'h0};
  wire [10:0] cur_index = lcd_pkg::lcd_ram_index(page, column);
  wire [10:0] drain_index = lcd_pkg::lcd_ram_index(fifo_out.page, fifo_out.col);
  wire [10:0] refresh_index = lcd_pkg::lcd_ram_index(refresh_page, refresh_col);
  wire drain = fifo_out_valid && drain_ready;

  assign fifo_in = '{page: page, col: column, data: data_in};
  assign wr_ready = fifo_in_ready;

  // ----------------------------------------------------------------
  // configuration next value
  // ----------------------------------------------------------------
  always_comb begin
    next_cfg = cfg;
    if (cmd_wr) begin
      if (is_disp) begin
        next_cfg.display_on = data_in[0];
      end
      if (is_seg) begin
        next_cfg.seg_reverse = data_in[0];
      end
      if (is_invert) begin
        next_cfg.invert = data_in[0];
      end
      if (is_all_on) begin
        next_cfg.all_on = data_in[0];
      end
      if (is_bias) begin
        next_cfg.bias_alt = data_in[0];
      end
      if (is_com) begin
        next_cfg.com_reverse = data_in[3];
      end
      if (is_power) begin
        next_cfg.power_ctrl = data_in[2:0];
      end
      if (is_ratio) begin
        next_cfg.ratio = data_in[2:0];
      end
      if (is_line) begin
        next_cfg.start_line = data_in[5:0];
      end
      if (is_test) begin
        next_cfg.test_mode = 1'b1;
      end
      if (is_reset) begin
        // power control, bias and display modes are kept
        next_cfg.start_line = lcd_pkg::LCD_LINE_RESET;
        next_cfg.com_reverse = 1'b0;
        next_cfg.ratio = lcd_pkg::LCD_RATIO_RESET;
        next_cfg.test_mode = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // address next value
  // ----------------------------------------------------------------
  always_comb begin
    next_column = column;
    next_page = page;
    next_rmw = rmw;
    if (cmd_wr && is_col_hi) begin
      next_column = {data_in[3:0], column[3:0]};
    end
    if (cmd_wr && is_col_lo) begin
      next_column = {column[7:4], data_in[3:0]};
    end
    if (cmd_wr && is_page) begin
      next_page = data_in[3:0];
    end
    if (cmd_wr && is_rmw) begin
      next_rmw = 1'b1;
    end
    if (cmd_wr && is_end && rmw) begin
      next_rmw = 1'b0;
      next_column = col_saved;
    end
    if (data_wr) begin
      next_column = lcd_pkg::lcd_col_step(column);
    end
    if (data_rd && !rmw) begin
      next_column = lcd_pkg::lcd_col_step(column);
    end
    if (reset_cmd) begin
      next_column = lcd_pkg::LCD_COL_RESET;
      next_page = lcd_pkg::LCD_PAGE_RESET;
      next_rmw = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // initialization sequencer
  // ----------------------------------------------------------------
  always_comb begin
    case (state)
      lcd_pkg::LCD_ST_INIT: next_state =
        (init_cnt == lcd_pkg::LCD_INIT_LAST) ? lcd_pkg::LCD_ST_RUN : lcd_pkg::LCD_ST_INIT;
      lcd_pkg::LCD_ST_RUN: next_state = reset_cmd ? lcd_pkg::LCD_ST_INIT : lcd_pkg::LCD_ST_RUN;
      default: next_state = lcd_pkg::LCD_ST_INIT;
    endcase
  end

  always_ff @(posedge clk) begin
    if (hard_rst) begin
      state <= lcd_pkg::LCD_ST_INIT;
      init_cnt <= 4'h0;
    end else begin
      state <= next_state;
      init_cnt <= (next_state == lcd_pkg::LCD_ST_INIT && initializing) ? init_cnt + 4'h1 : 4'h0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (hard_rst) begin
      cfg <= '{power_ctrl: lcd_pkg::LCD_POWER_RESET, ratio: lcd_pkg::LCD_RATIO_RESET,
               start_line: lcd_pkg::LCD_LINE_RESET, default: 1'b0};
      column <= lcd_pkg::LCD_COL_RESET;
      page <= lcd_pkg::LCD_PAGE_RESET;
      rmw <= 1'b0;
      col_saved <= lcd_pkg::LCD_COL_RESET;
    end else begin
      cfg <= next_cfg;
      column <= next_column;
      page <= next_page;
      rmw <= next_rmw;
      col_saved <= (cmd_wr && is_rmw && !rmw) ? column : col_saved;
    end
  end

  always_ff @(posedge clk) begin
    if (hard_rst) begin
      bias_den <= lcd_pkg::lcd_bias_den(2'h3, 1'b0);
      power_save <= 1'b0;
    end else begin
      bias_den <= lcd_pkg::lcd_bias_den(duty_sel, cfg.bias_alt);
      power_save <= cfg.all_on && !cfg.display_on;
    end
  end

  // ----------------------------------------------------------------
  // host read path
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (hard_rst) begin
      data_out <= 8'h00;
      data_oe_n <= 1'b1;
      read_latch <= 8'h00;
    end else begin
      data_oe_n <= !any_rd;
      if (any_rd) begin
        data_out <= command_data_select ? read_latch : status_byte;
      end
      if (data_rd || (cmd_wr && (is_col_hi || is_col_lo || is_page))) begin
        read_latch <= ram[cur_index];
      end
    end
  end

  // ----------------------------------------------------------------
  // display ram and write buffer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (drain) begin
      ram[drain_index] <= fifo_out.data;
    end
    refresh_data <= ram[refresh_index];
  end

  lcd_fifo #(
    .WIDTH($bits(lcd_pkg::lcd_wr_type)),
    .DEPTH(lcd_pkg::LCD_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(hard_rst),
    .in_valid(wr_strobe && command_data_select),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(fifo_out_valid),
    .out_ready(drain_ready),
    .out_data(fifo_out)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_BUSY_REJECT: assert property (@(posedge clk) disable iff (hard_rst)
    (wr_strobe && !command_data_select && busy && !is_reset) |=> $stable(cfg))
    else $error("command taken while busy");

  AST_STATUS_BYTE: assert property (@(posedge clk) disable iff (hard_rst)
    (rd_strobe && !command_data_select) |=>
      (data_out[6] == !$past(cfg.seg_reverse)) && !data_oe_n)
    else $error("status direction bit wrong");

  AST_STATUS_OFF_LOW: assert property (@(posedge clk) disable iff (hard_rst)
    (rd_strobe && !command_data_select) |=>
      (data_out[5] == !$past(cfg.display_on)) && (data_out[3:0] == 4'h0))
    else $error("status on/off or low bits wrong");

  AST_INIT_LEN: assert property (@(posedge clk) disable iff (hard_rst)
    reset_cmd |=> initializing [*8] ##1 !initializing)
    else $error("initialization length wrong");

  AST_WR_ADV: assert property (@(posedge clk) disable iff (hard_rst)
    (data_wr && column != lcd_pkg::LCD_COL_LAST && !cmd_wr) |=>
      column == $past(column) + 8'h01)
    else $error("column did not advance on write");

  AST_RD_ADV: assert property (@(posedge clk) disable iff (hard_rst)
    (data_rd && !rmw && column != lcd_pkg::LCD_COL_LAST && !data_wr) |=>
      column == $past(column) + 8'h01)
    else $error("column did not advance on read");

  AST_SERIAL_NO_READ: assert property (@(posedge clk) disable iff (hard_rst)
    (rd_strobe && command_data_select && serial_mode) |=> data_oe_n && $stable(column))
    else $error("display data read in serial mode");

  AST_RMW_HOLD: assert property (@(posedge clk) disable iff (hard_rst)
    (rd_strobe && command_data_select && rmw && !wr_strobe) |=> $stable(column))
    else $error("read advanced column in rmw");

  AST_END_RESTORE: assert property (@(posedge clk) disable iff (hard_rst)
    (cmd_wr && is_end && rmw) |=> !rmw && column == $past(col_saved))
    else $error("end did not restore column");

  AST_RESET_CMD: assert property (@(posedge clk) disable iff (hard_rst)
    reset_cmd |=> column == 8'h00 && page == 4'h0 && $stable(cfg.power_ctrl))
    else $error("reset command effect wrong");

  AST_POWER_SAVE: assert property (@(posedge clk) disable iff (hard_rst)
    (cfg.all_on && !cfg.display_on) [*2] |-> power_save)
    else $error("power save not entered");

  AST_STATUS_FLAGS: assert property (@(posedge clk) disable iff (hard_rst)
    (rd_strobe && !command_data_select) |=>
      (data_out[7] == $past(busy)) && (data_out[4] == $past(initializing)))
    else $error("status busy or init bit wrong");

  AST_WR_REFUSED: assert property (@(posedge clk) disable iff (hard_rst)
    (wr_strobe && command_data_select && !fifo_in_ready && !rd_strobe) |=> $stable(column))
    else $error("refused data write moved column");

endmodule

`default_nettype wire

// ==== hw/lcd_pkg.sv ====
// Purpose: constants, types and helpers for the lcd command decoder
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes: shared by the decoder and its bench

package lcd_pkg;

  // ----------------------------------------------------------------
  // geometry and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] LCD_COL_LAST = 8'h83;
  localparam logic [10:0] LCD_COL_COUNT = 11'h084;
  localparam int LCD_RAM_WORDS = 1188;
  localparam int LCD_FIFO_DEPTH = 4;
  localparam int LCD_CLK_PERIOD_NS = 10;
  localparam int LCD_INIT_TIME_NS = 80;
  localparam int LCD_INIT_CYCLES_INT =
    (LCD_INIT_TIME_NS + LCD_CLK_PERIOD_NS - 1) / LCD_CLK_PERIOD_NS;
  localparam logic [3:0] LCD_INIT_LAST = 4'(LCD_INIT_CYCLES_INT - 1);

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] LCD_RATIO_RESET = 3'h4;
  localparam logic [2:0] LCD_POWER_RESET = 3'h0;
  localparam logic [7:0] LCD_COL_RESET = 8'h00;
  localparam logic [3:0] LCD_PAGE_RESET = 4'h0;
  localparam logic [5:0] LCD_LINE_RESET = 6'h00;

  // ----------------------------------------------------------------
  // status byte fields
  // ----------------------------------------------------------------
  localparam int LCD_ST_BUSY_BIT = 7;
  localparam int LCD_ST_DIR_BIT = 6;
  localparam int LCD_ST_OFF_BIT = 5;
  localparam int LCD_ST_INIT_BIT = 4;

  // ----------------------------------------------------------------
  // command codes (exact, or with bit 0 masked for the mode commands) and prefixes (masked)
  // ----------------------------------------------------------------
  localparam logic [7:0] LCD_CMD_DISP_OFF = 8'hae;
  localparam logic [7:0] LCD_CMD_DISP_ON = 8'haf;
  localparam logic [7:0] LCD_CMD_SEG_DIR = 8'ha0;
  localparam logic [7:0] LCD_CMD_BIAS = 8'ha2;
  localparam logic [7:0] LCD_CMD_ALL_ON = 8'ha4;
  localparam logic [7:0] LCD_CMD_INVERT = 8'ha6;
  localparam logic [7:0] LCD_CMD_RMW = 8'he0;
  localparam logic [7:0] LCD_CMD_END = 8'hee;
  localparam logic [7:0] LCD_CMD_RESET = 8'he2;
  localparam logic [7:0] LCD_MASK_BIT0 = 8'hfe;
  localparam logic [7:0] LCD_MASK_NIB = 8'hf0;
  localparam logic [7:0] LCD_MASK_3BIT = 8'hf8;
  localparam logic [7:0] LCD_MASK_LINE = 8'hc0;
  localparam logic [7:0] LCD_PFX_COL_HI = 8'h10;
  localparam logic [7:0] LCD_PFX_COL_LO = 8'h00;
  localparam logic [7:0] LCD_PFX_PAGE = 8'hb0;
  localparam logic [7:0] LCD_PFX_COM = 8'hc0;
  localparam logic [7:0] LCD_PFX_TEST = 8'hf0;
  localparam logic [7:0] LCD_PFX_POWER = 8'h28;
  localparam logic [7:0] LCD_PFX_RATIO = 8'h20;
  localparam logic [7:0] LCD_PFX_LINE = 8'h40;
  localparam logic [3:0] LCD_PAGE_LAST = 4'h8;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LCD_ST_INIT = 2'b00,
    LCD_ST_RUN = 2'b01
  } lcd_state_type;

  typedef struct packed {
    logic [3:0] page;
    logic [7:0] col;
    logic [7:0] data;
  } lcd_wr_type;

  typedef struct packed {
    logic display_on;
    logic seg_reverse;
    logic invert;
    logic all_on;
    logic bias_alt;
    logic com_reverse;
    logic test_mode;
    logic [2:0] power_ctrl;
    logic [2:0] ratio;
    logic [5:0] start_line;
  } lcd_cfg_type;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [10:0] lcd_ram_index(input logic [3:0] page,
                                                input logic [7:0] col);
    lcd_ram_index = 11'(page * LCD_COL_COUNT) + {3'h0, col};
  endfunction

  function automatic logic [7:0] lcd_col_step(input logic [7:0] col);
    lcd_col_step = (col == LCD_COL_LAST) ? col : col + 8'h01;
  endfunction

  // bias denominator for duty code 0..3 = 1/33, 1/49, 1/55, 1/65
  function automatic logic [3:0] lcd_bias_den(input logic [1:0] duty,
                                              input logic alt);
    case ({alt, duty})
      3'b000: lcd_bias_den = 4'h6;
      3'b001: lcd_bias_den = 4'h8;
      3'b010: lcd_bias_den = 4'h8;
      3'b011: lcd_bias_den = 4'h9;
      3'b100: lcd_bias_den = 4'h5;
      3'b101: lcd_bias_den = 4'h6;
      3'b110: lcd_bias_den = 4'h6;
      default: lcd_bias_den = 4'h7;
    endcase
  endfunction

endpackage

// ==== verif/lcd_cmd_decoder_tb.sv ====
// Purpose: self-checking bench of the lcd command decoder
// Assumes: 100 MHz clock, synchronous active-high reset
// Notes: ram contents are mirrored in an associative array
`timescale 1ns/10ps
`default_nettype none
module lcd_cmd_decoder_tb;
  logic clk;
  logic rst;
  logic hw_rst_n;
  logic serial_mode;
  logic [1:0] duty_sel;
  logic refresh_req;
  logic [3:0] refresh_page;
  logic [7:0] refresh_col;
  wire logic cds, rd_strobe, wr_strobe, data_oe_n, wr_ready, power_save;
  wire logic [7:0] data_in, data_out, refresh_data;
  wire logic [3:0] bias_den;
  lcd_pkg::lcd_cfg_type cfg;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  int seed = 32'h92ec;
  int den[8] = '{6, 8, 8, 9, 5, 6, 6, 7};
  logic [7:0] base[4] = '{8'ha0, 8'ha6, 8'ha4, 8'ha2};
  logic [7:0] mem[int];
  logic [7:0] b, c, pg, xv, yv, zv;
  logic [3:0] fld;
  logic [2:0] pw, rt;
  logic [5:0] ln;

  always #5 clk = ~clk;

  lcd_host_model H (.clk(clk), .data_out(data_out), .data_oe_n(data_oe_n), .cds(cds),
    .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .data_in(data_in));

  lcd_cmd_decoder DUT (.clk(clk), .rst(rst), .hardware_reset_n(hw_rst_n),
    .serial_mode(serial_mode), .duty_sel(duty_sel), .command_data_select(cds),
    .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .wr_ready(wr_ready), .refresh_req(refresh_req),
    .refresh_page(refresh_page), .refresh_col(refresh_col), .refresh_data(refresh_data),
    .cfg(cfg), .bias_den(bias_den), .power_save(power_save));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    hw_rst_n = 1'b1;
    serial_mode = 1'b0;
    refresh_req = 1'b0;
    refresh_page = 4'h0;
    refresh_col = 8'h00;
    duty_sel = 2'($random(seed));
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    H.rd(1'b0);
    check("init status", H.rd_val, 8'hf0);
    H.wr(1'b0, lcd_pkg::LCD_CMD_DISP_ON);
    H.poll();
    check("busy drop", H.rd_val, 8'h60);
    for (int i = 0; i < 4; i++) begin
      for (int v = 1; v >= 0; v--) begin
        H.cmd(base[i] | 8'(v));
        fld = {cfg.seg_reverse, cfg.invert, cfg.all_on, cfg.bias_alt};
        check("mode bit", 8'(fld[3 - i]), 8'(v));
        H.poll();
        if (i == 3) check("bias", 8'(bias_den), 8'(den[{v[0], duty_sel}]));
        check("status", H.rd_val, (i == 0 && v == 1) ? 8'h20 : 8'h60);
        check("power save", 8'(power_save), 8'(i == 2 && v == 1));
      end
    end
    H.cmd(lcd_pkg::LCD_CMD_DISP_ON);
    H.poll();
    check("status on", H.rd_val, 8'h40);
    pw = 3'($random(seed)) | 3'h1;
    rt = 3'($random(seed)) & 3'h3;
    ln = 6'($random(seed)) | 6'h01;
    H.cmd(lcd_pkg::LCD_PFX_POWER | {5'h0, pw});
    H.cmd(lcd_pkg::LCD_PFX_RATIO | {5'h0, rt});
    H.cmd(lcd_pkg::LCD_PFX_COM | 8'h08 | 8'(rt));
    check("power", 8'(cfg.power_ctrl), 8'(pw));
    check("ratio", 8'(cfg.ratio), 8'(rt));
    check("com scan", 8'(cfg.com_reverse), 8'h01);
    H.cmd(lcd_pkg::LCD_PFX_LINE | {2'h0, ln});
    H.cmd(lcd_pkg::LCD_PFX_TEST);
    check("start line", 8'(cfg.start_line), 8'(ln));
    check("test mode", 8'(cfg.test_mode), 8'h01);
    pg = 8'($random(seed)) & 8'h07;
    c = 8'($random(seed)) & 8'h7f;
    H.cmd(lcd_pkg::LCD_PFX_PAGE | pg);
    H.col(c, 1'b0);
    @(negedge clk);
    refresh_req = 1'b1;
    for (int k = 0; k < 5; k++) begin
      b = 8'($random(seed));
      check("wr ready", 8'(wr_ready), 8'(k < 4));
      if (k < 4) mem[pg * 132 + c + k] = b;
      H.wr(1'b1, b);
    end
    refresh_req = 1'b0;
    refresh_page = pg[3:0];
    refresh_col = c;
    H.col(c, 1'b1);
    check("refresh", refresh_data, mem[pg * 132 + c]);
    for (int k = 0; k < 4; k++) begin
      H.rd(1'b1);
      check("ram read", H.rd_val, mem[pg * 132 + c + k]);
    end
    xv = 8'($random(seed));
    yv = 8'($random(seed));
    zv = 8'($random(seed));
    H.col(c, 1'b0);
    H.cmd(lcd_pkg::LCD_CMD_RMW);
    H.rd(1'b1);
    H.rd(1'b1);
    H.wr(1'b1, xv);
    H.wr(1'b1, yv);
    H.cmd(lcd_pkg::LCD_CMD_END);
    H.wr(1'b1, zv);
    H.col(c, 1'b1);
    H.rd(1'b1);
    check("end restore", H.rd_val, zv);
    H.rd(1'b1);
    check("rmw step", H.rd_val, yv);
    H.cmd(lcd_pkg::LCD_CMD_RESET);
    H.rd(1'b0);
    check("reset init", 8'(H.rd_val[4]), 8'h01);
    check("ratio clr", 8'(cfg.ratio), 8'h04);
    check("scan clr", 8'(cfg.com_reverse), 8'h00);
    check("line clr", 8'(cfg.start_line), 8'h00);
    check("test clr", 8'(cfg.test_mode), 8'h00);
    check("power kept", 8'(cfg.power_ctrl), 8'(pw));
    H.poll();
    @(negedge clk);
    hw_rst_n = 1'b0;
    @(negedge clk);
    hw_rst_n = 1'b1;
    check("power pin", 8'(cfg.power_ctrl), 8'h00);
    H.poll();
    serial_mode = 1'b1;
    H.rd(1'b1);
    check("serial read", 8'(H.got), 8'h00);
    serial_mode = 1'b0;
    final_report();
  end
endmodule
`default_nettype wire

// ==== verif/lcd_host_model.sv ====
// Purpose: host processor on the parallel bus of the lcd command decoder
// Assumes: drives on the falling edge; strobes are one-cycle pulses
// Notes: polls busy before commands; released data lines show inverted values
`timescale 1ns/10ps
`default_nettype none
module lcd_host_model (
  input wire logic clk,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n,
  output logic cds,
  output logic rd_strobe,
  output logic wr_strobe,
  output logic [7:0] data_in
);
  logic [7:0] rd_val;
  logic got;
  initial begin
    cds = 1'b0;
    rd_strobe = 1'b0;
    wr_strobe = 1'b0;
    data_in = 8'h00;
  end
  task automatic wr(input logic sel, input logic [7:0] b);
    @(negedge clk);
    cds = sel;
    data_in = b;
    wr_strobe = 1'b1;
    @(negedge clk);
    wr_strobe = 1'b0;
    data_in = ~b;
  endtask
  task automatic rd(input logic sel);
    @(negedge clk);
    cds = sel;
    rd_strobe = 1'b1;
    rd_val = 8'hxx;
    got = 1'b0;
    @(negedge clk);
    rd_strobe = 1'b0;
    repeat (2) begin
      if (data_oe_n === 1'b0) begin
        rd_val = data_out;
        got = 1'b1;
      end
      @(negedge clk);
    end
  endtask
  task automatic poll();
    for (int i = 0; i < 40; i++) begin
      rd(1'b0);
      if (rd_val[7] === 1'b0) break;
    end
  endtask
  task automatic cmd(input logic [7:0] b);
    poll();
    wr(1'b0, b);
  endtask
  task automatic col(input logic [7:0] c, input logic dummy);
    cmd(8'h10 | {4'h0, c[7:4]});
    cmd({4'h0, c[3:0]});
    if (dummy) rd(1'b1);
  endtask
endmodule
`default_nettype wire
